// ---- rtl/car_pkg.sv ----
// package: offsets, field layouts, reset values and types of the current result registers
package car_pkg;
    // register offsets on the device register interface
    localparam logic [7:0] CAR_OFS_IIN_HI = 8'h17;
    localparam logic [7:0] CAR_OFS_IIN_LO = 8'h18;
    localparam logic [7:0] CAR_OFS_ICH_HI = 8'h19;
    localparam logic [7:0] CAR_OFS_ICH_LO = 8'h1A;
    // reset values
    localparam logic [7:0]  CAR_RST_BYTE   = 8'h00;
    localparam logic [15:0] CAR_RST_IIN    = 16'h0000;
    localparam logic [14:0] CAR_RST_ICH    = 15'h0000;
    // field layout
    localparam int CAR_IIN_W       = 16;
    localparam int CAR_ICH_W       = 15;
    localparam int CAR_ICH_HI_W    = 7;
    localparam int CAR_RSVD_BIT    = 7;
    localparam logic CAR_RSVD_VAL  = 1'b0;
    // conversion rate encoding
    localparam logic CAR_RATE_CONT = 1'b0;
    localparam logic CAR_RATE_ONE  = 1'b1;

    // converter control bits from neighbouring control registers
    typedef struct packed {
        logic conv_en;
        logic conv_rate;
        logic input_current_conv_off;
        logic charge_current_conv_off;
    } car_ctrl_t;

    // one sample delivered by the converter
    typedef struct packed {
        logic        valid;
        logic [15:0] input_current;
        logic [14:0] charge_current;
    } car_sample_t;

    // register read port
    typedef struct packed {
        logic       rd;
        logic [7:0] addr;
    } car_rdreq_t;
endpackage

// ---- rtl/car_capture.sv ----
// module: update gating for a converter sample according to enable, rate and disables
`timescale 1ns/100ps
module car_capture
    import car_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // control and sample
    input  wire car_ctrl_t   ctrl,
    input  wire car_sample_t sample,
    input  wire logic        reg_reset,
    // update strobes and one-shot state
    output logic             upd_iin,
    output logic             upd_ich,
    output logic             oneshot_done
);
    logic one_taken_q;
    logic one_taken_d;
    logic conv_ok;

    // enable and rate gate
    // one-shot takes just the first sample after enable or register reset; re-arms when enable drops or on register reset
    assign conv_ok = ctrl.conv_en && sample.valid &&
                     (ctrl.conv_rate == CAR_RATE_CONT || !one_taken_q);
    assign upd_iin = conv_ok && !ctrl.input_current_conv_off;
    assign upd_ich = conv_ok && !ctrl.charge_current_conv_off;
    assign oneshot_done = one_taken_q;

    // one-shot bookkeeping
    assign one_taken_d = (!ctrl.conv_en || reg_reset) ? 1'b0 :
                         (conv_ok && ctrl.conv_rate == CAR_RATE_ONE) ? 1'b1 : one_taken_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            one_taken_q <= 1'b0;
        end else begin
            one_taken_q <= one_taken_d;
        end
    end
endmodule

// ---- rtl/car_result_regs.sv ----
// module: read-only input current and charge current result registers
`timescale 1ns/100ps
module car_result_regs
    import car_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // device control
    input  wire car_ctrl_t   ctrl,
    input  wire logic        reg_reset,
    input  wire logic        watchdog_expired,
    // converter sample, same clock domain
    input  wire car_sample_t sample,
    // register read port
    input  wire car_rdreq_t  rdreq,
    output logic [7:0]       rdata,
    output logic             rhit,
    // state
    output logic             oneshot_done
);
    logic [15:0] iin_q;
    logic [15:0] iin_d;
    logic [14:0] ich_q;
    logic [14:0] ich_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic        upd_iin;
    logic        upd_ich;
    logic [7:0]  ich_hi_byte;

    // update gating lives in a small helper
    car_capture u_car_capture (
        .clk          (clk),
        .resetn       (resetn),
        .ctrl         (ctrl),
        .sample       (sample),
        .reg_reset    (reg_reset),
        .upd_iin      (upd_iin),
        .upd_ich      (upd_ich),
        .oneshot_done (oneshot_done)
    );

    // register reset clears
    // watchdog is deliberately not used here; results survive its expiry
    // signed sample stored as is
    assign iin_d = reg_reset ? CAR_RST_IIN : (upd_iin ? sample.input_current : iin_q);
    assign ich_d = reg_reset ? CAR_RST_ICH : (upd_ich ? sample.charge_current : ich_q);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            iin_q <= CAR_RST_IIN;
            ich_q <= CAR_RST_ICH;
        end else begin
            iin_q <= iin_d;
            ich_q <= ich_d;
        end
    end

    assign ich_hi_byte = {CAR_RSVD_VAL, ich_q[CAR_ICH_W-1:8]};

    // one decode of the four result offsets, shared by the hit flag and the unmapped-read data check
    function automatic logic is_result_addr(input logic [7:0] addr);
        return addr == CAR_OFS_IIN_HI || addr == CAR_OFS_IIN_LO ||
               addr == CAR_OFS_ICH_HI || addr == CAR_OFS_ICH_LO;
    endfunction

    // byte split of the input current
    // byte split of the charge current
    assign rhit = rdreq.rd && is_result_addr(rdreq.addr);
    assign rdata_d = !rdreq.rd                  ? rdata_q :
                     rdreq.addr == CAR_OFS_IIN_HI ? iin_q[15:8] :
                     rdreq.addr == CAR_OFS_IIN_LO ? iin_q[7:0] :
                     rdreq.addr == CAR_OFS_ICH_HI ? ich_hi_byte :
                     rdreq.addr == CAR_OFS_ICH_LO ? ich_q[7:0] : CAR_RST_BYTE;

    // read-only, only a read data latch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= CAR_RST_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign rdata = rdata_q;

    property p_rst_clears;
        @(posedge clk) disable iff (!resetn)
        reg_reset |=> (iin_q == 16'h0000 && ich_q == 15'h0000);
    endproperty
    a_rst_clears: assert property (p_rst_clears) else $error("results not cleared");

    property p_wd_keeps;
        @(posedge clk) disable iff (!resetn)
        (watchdog_expired && !reg_reset && !upd_iin) |=> $stable(iin_q);
    endproperty
    a_wd_keeps: assert property (p_wd_keeps) else $error("watchdog changed result");

    property p_off_holds;
        @(posedge clk) disable iff (!resetn)
        (!ctrl.conv_en && !reg_reset) |=> ($stable(iin_q) && $stable(ich_q));
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("update while disabled");

    sequence s_one_taken;
        ctrl.conv_en && ctrl.conv_rate && upd_iin && !reg_reset;
    endsequence
    property p_one_once;
        @(posedge clk) disable iff (!resetn)
        s_one_taken ##1 (ctrl.conv_en && ctrl.conv_rate && !reg_reset) |-> !upd_iin;
    endproperty
    a_one_once: assert property (p_one_once) else $error("second one-shot update");

    property p_iin_off;
        @(posedge clk) disable iff (!resetn)
        (ctrl.input_current_conv_off && !reg_reset) |=> $stable(iin_q);
    endproperty
    a_iin_off: assert property (p_iin_off) else $error("input channel updated");

    property p_ich_off;
        @(posedge clk) disable iff (!resetn)
        (ctrl.charge_current_conv_off && !reg_reset) |=> $stable(ich_q);
    endproperty
    a_ich_off: assert property (p_ich_off) else $error("charge channel updated");

    // high byte read returns bits 15:8 of the input current
    property p_hi_read;
        @(posedge clk) disable iff (!resetn)
        (rdreq.rd && rdreq.addr == CAR_OFS_IIN_HI) |=> rdata == $past(iin_q[15:8]);
    endproperty
    a_hi_read: assert property (p_hi_read) else $error("bad input high byte");

    property p_rsvd;
        @(posedge clk) disable iff (!resetn)
        (rdreq.rd && rdreq.addr == CAR_OFS_ICH_HI) |=> rdata[7] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_ich_lo;
        @(posedge clk) disable iff (!resetn)
        (rdreq.rd && rdreq.addr == CAR_OFS_ICH_LO) |=> rdata == $past(ich_q[7:0]);
    endproperty
    a_ich_lo: assert property (p_ich_lo) else $error("bad charge low byte");

    // stored value is the signed sample
    property p_sign;
        @(posedge clk) disable iff (!resetn)
        (upd_iin && !reg_reset) |=> iin_q[15] == $past(sample.input_current[15]);
    endproperty
    a_sign: assert property (p_sign) else $error("sign lost");

    property p_iin_lo;
        @(posedge clk) disable iff (!resetn)
        (rdreq.rd && rdreq.addr == CAR_OFS_IIN_LO) |=> rdata == $past(iin_q[7:0]);
    endproperty
    a_iin_lo: assert property (p_iin_lo) else $error("bad input low byte");

    property p_ich_hi;
        @(posedge clk) disable iff (!resetn)
        (rdreq.rd && rdreq.addr == CAR_OFS_ICH_HI) |=> rdata[6:0] == $past(ich_q[14:8]);
    endproperty
    a_ich_hi: assert property (p_ich_hi) else $error("bad charge high byte");

    property p_miss;
        @(posedge clk) disable iff (!resetn)
        (rdreq.rd && !is_result_addr(rdreq.addr)) |=> rdata == CAR_RST_BYTE;
    endproperty
    a_miss: assert property (p_miss) else $error("unmapped read not zero");

    property p_ro;
        @(posedge clk) disable iff (!resetn)
        (rdreq.rd && !reg_reset && !upd_iin && !upd_ich) |=> ($stable(iin_q) && $stable(ich_q));
    endproperty
    a_ro: assert property (p_ro) else $error("read changed a result");

    // every bit kept at its weight
    property p_weight;
        @(posedge clk) disable iff (!resetn)
        (upd_iin && !reg_reset) |=> iin_q == $past(sample.input_current);
    endproperty
    a_weight: assert property (p_weight) else $error("input value altered");

    property p_ich_store;
        @(posedge clk) disable iff (!resetn)
        (upd_ich && !reg_reset) |=> ich_q == $past(sample.charge_current);
    endproperty
    a_ich_store: assert property (p_ich_store) else $error("charge value altered");

    property p_cont;
        @(posedge clk) disable iff (!resetn)
        (ctrl.conv_en && ctrl.conv_rate == CAR_RATE_CONT && sample.valid &&
         !ctrl.charge_current_conv_off) |-> upd_ich;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous sample dropped");

    property p_shot_flag;
        @(posedge clk) disable iff (!resetn)
        (upd_iin && ctrl.conv_rate == CAR_RATE_ONE && !reg_reset) |=> oneshot_done;
    endproperty
    a_shot_flag: assert property (p_shot_flag) else $error("one-shot not marked done");
endmodule

// ---- test/car_host.sv ----
// host-side reader: single-byte reads on the device register read port
`timescale 1ns/100ps
module car_host
    import car_pkg::*;
(
    // clock
    input  wire logic       clk,
    // read port
    output car_rdreq_t      rdreq,
    input  wire logic [7:0] rdata,
    input  wire logic       rhit
);
    // idle address is the inverse of the last one, so a stale address never looks valid
    initial rdreq = '0;

    // request held one full cycle, data taken at the falling edge half a cycle after the edge that latches it
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge clk) rdreq <= '{rd: 1'b1, addr: a};
        @(negedge clk) h = rhit;
        @(posedge clk) rdreq <= '{rd: 1'b0, addr: ~a};
        @(negedge clk) d = rdata;
    endtask
endmodule

// ---- test/car_result_regs_tb.sv ----
// testbench: current result registers against an integer reference model
`timescale 1ns/100ps
module car_result_regs_tb import car_pkg::*; ;
    logic        clk = 0, resetn = 0, reg_reset = 0, watchdog_expired = 0, rhit, oneshot_done, h;
    car_ctrl_t   ctrl = '0;
    car_sample_t sample = '0;
    wire car_rdreq_t rdreq;
    logic [7:0]  rdata, d;
    int          errors = 0, n_compared = 0, m_iin = 0, m_ich = 0, m_shot = 0;

    car_result_regs u_car_result_regs (.clk(clk), .resetn(resetn), .ctrl(ctrl),
        .reg_reset(reg_reset), .watchdog_expired(watchdog_expired), .sample(sample),
        .rdreq(rdreq), .rdata(rdata), .rhit(rhit), .oneshot_done(oneshot_done));
    car_host u_car_host (.clk(clk), .rdreq(rdreq), .rdata(rdata), .rhit(rhit));

    // 50 ns period
    initial forever #25 clk = ~clk;

    task automatic close_out;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        u_car_host.read(a, d, h);
        chk("rdata", e, d);
        chk("rhit", 8'h01, {7'h00, h});
    endtask

    // all four bytes from the model, plus an unmapped neighbour
    task automatic rd_all;
        logic [15:0] i;
        logic [14:0] c;
        i = m_iin[15:0];
        c = m_ich[14:0];
        rd_chk(CAR_OFS_IIN_HI, i[15:8]);
        rd_chk(CAR_OFS_IIN_LO, i[7:0]);
        rd_chk(CAR_OFS_ICH_HI, {1'b0, c[14:8]});
        rd_chk(CAR_OFS_ICH_LO, c[7:0]);
        u_car_host.read(8'h1B, d, h);
        chk("rhit", 8'h00, {7'h00, h});
        chk("oneshot", 8'(m_shot), {7'h00, oneshot_done});
    endtask

    // dropping the enable re-arms one-shot in the model
    task automatic setc(input logic en, rate, offi, offc);
        @(posedge clk) ctrl <= '{en, rate, offi, offc};
        if (!en) m_shot = 0;
    endtask

    task automatic conv(input logic [15:0] i, input logic [14:0] c);
        @(posedge clk) sample <= {1'b1, i, c};
        @(posedge clk) sample.valid <= 1'b0;
        if (ctrl.conv_en && (!ctrl.conv_rate || m_shot == 0)) begin
            if (!ctrl.input_current_conv_off) m_iin = i;
            if (!ctrl.charge_current_conv_off) m_ich = c;
            if (ctrl.conv_rate) m_shot = 1;
        end
    endtask

    initial begin
        void'($urandom(32'hE7C8));
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rd_all;
        setc(1, 0, 0, 0);
        repeat (6) begin
            conv(16'($urandom), 15'($urandom));
            rd_all;
        end
        conv(16'h8000, 15'h7FFF);
        rd_all;
        for (int k = 0; k < 4; k++) begin
            setc(1, 0, k[0], k[1]);
            conv(16'($urandom), 15'($urandom));
            rd_all;
        end
        setc(0, 0, 0, 0);
        conv(16'h7FFF, 15'h1234);
        rd_all;
        setc(1, 1, 0, 0);
        conv(16'hFFFF, 15'h0001);
        conv(16'h0100, 15'h0200);
        rd_all;
        setc(0, 1, 0, 0);
        setc(1, 1, 0, 0);
        conv(16'h4000, 15'h4000);
        rd_all;
        @(posedge clk) watchdog_expired <= 1'b1;
        @(posedge clk) watchdog_expired <= 1'b0;
        rd_all;
        @(posedge clk) reg_reset <= 1'b1;
        @(posedge clk) reg_reset <= 1'b0;
        m_iin = 0;
        m_ich = 0;
        m_shot = 0;
        rd_all;
        setc(1, 0, 0, 0);
        conv(16'($urandom), 15'($urandom));
        rd_all;
        // register reset and a sample on the same edge: the reset wins
        @(posedge clk) begin
            sample <= {1'b1, 16'h5A5A, 15'h2A2A};
            reg_reset <= 1'b1;
        end
        @(posedge clk) begin
            sample.valid <= 1'b0;
            reg_reset <= 1'b0;
        end
        m_iin = 0;
        m_ich = 0;
        rd_all;
        // mid-run asynchronous reset brings the results back to zero
        conv(16'($urandom), 15'($urandom));
        @(posedge clk) resetn <= 1'b0;
        @(posedge clk) resetn <= 1'b1;
        m_iin = 0;
        m_ich = 0;
        m_shot = 0;
        rd_all;
        close_out;
    end

    // about 2000 cycles, several times what the sequence needs
    initial begin
        #100000;
        errors++;
        close_out;
    end
endmodule
